// File: src/can_fifo_status_consts.vh
`ifndef CAN_FIFO_STATUS_CONSTS_VH
`define CAN_FIFO_STATUS_CONSTS_VH

// Register blocks, selected by address bits 7:4
`define BLK_FLAGS_ENABLES      4'h0
`define BLK_SW_ADDRESS         4'h1
`define BLK_FIFO_CONTROL       4'h2
`define BLK_IRQ                4'h3

// Alias operation, selected by address bits 3:2
`define OP_WRITE               2'h0
`define OP_CLEAR               2'h1
`define OP_SET                 2'h2
`define OP_INVERT              2'h3

// Interrupt block word offsets, selected by address bits 3:2
`define IRQ_STATUS_WORD        2'h0
`define IRQ_CLEAR_WORD         2'h1
`define IRQ_ENABLE_WORD        2'h2

// Flags and enables register layout
`define TX_SPACE_EN_BIT        26
`define TX_HALF_EN_BIT         25
`define TX_DRAINED_EN_BIT      24
`define RX_OVERRUN_EN_BIT      19
`define RX_PACKED_EN_BIT       18
`define RX_HALF_EN_BIT         17
`define RX_PENDING_EN_BIT      16
`define TX_SPACE_FLAG_BIT      10
`define TX_HALF_FLAG_BIT       9
`define TX_DRAINED_FLAG_BIT    8
`define RX_OVERRUN_FLAG_BIT    3
`define RX_PACKED_FLAG_BIT     2
`define RX_HALF_FLAG_BIT       1
`define RX_PENDING_FLAG_BIT    0

// FIFO control register layout
`define FIFO_SIZE_MSB          20
`define FIFO_SIZE_LSB          16
`define FIFO_ADVANCE_BIT       13
`define FIFO_DIRECTION_BIT     7

// Operating mode that counts as configuration
`define OPMODE_CONFIG          3'h4

// Reset values
`define FLAGS_ENABLES_RESET    32'h00000000
`define FIFO_CONTROL_RESET     32'h00000000
`define IRQ_ENABLE_RESET       7'h00

// Event count for the sticky interrupt status
`define NUM_EVENTS             7

`endif

// File: src/can_fifo_status_irq.v
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Transmit interrupt enables at bits 26, 25, 24, read/write, zero at reset.
// - Receive interrupt enables at bits 19, 18, 17, 16, read/write, zero at reset.
// - Bit 10 shows transmit FIFO has space; reads zero in receive mode.
// - Bit 9 set while transmit occupancy at most half depth; zero for receive.
// - Bit 8 set while transmit FIFO holds no message; zero for receive.
// - Bit 3 latches receive overflow, software may clear it; zero for transmit.
// - Bit 2 set while every receive slot is filled; zero for transmit.
// - Bit 1 set while receive occupancy at least half depth; zero for transmit.
// - Bit 0 set while receive FIFO holds a message; zero for transmit.
// - Occupancy flags are computed from FIFO state and ignore writes.
// - Aliases at +0x4, +0x8, +0xC clear, set, invert writable bits; read zero.
// - Transmit mode user address is the head, where software writes next.
// - Receive mode user address is the tail, where software reads next.
// - User address is read-only, its two low bits always read zero.
// - Direction bit one means transmit FIFO, zero means receive FIFO.
// - Advance bit moves head or tail by one message; flags and address follow.
// - Configuration mode is operating mode status equal to 100.
`include "can_fifo_status_consts.vh"

module can_fifo_status_irq (
	input  wire        clk_sys_i,
	input  wire        reset_i,
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [31:0] rdata_o,
	input  wire [2:0]  operating_mode_status_i,
	input  wire [31:0] fifo_base_addr_i,
	input  wire [7:0]  msg_bytes_i,
	input  wire        can_msg_done_i,
	output wire [4:0]  can_side_index_o,
	output wire        fifo_irq_req_o,
	output wire        irq_o
);

	function [31:0] apply_op;
		input [1:0]  op;
		input [31:0] cur;
		input [31:0] val;
		begin
			case (op)
				`OP_WRITE:  apply_op = val;
				`OP_CLEAR:  apply_op = cur & ~val;
				`OP_SET:    apply_op = cur | val;
				default:    apply_op = cur ^ val;
			endcase
		end
	endfunction

	reg  [2:0]                tx_en_reg;
	reg  [3:0]                rx_en_reg;
	reg                       rx_overrun_flag_reg;
	reg                       fifo_direction_sel_reg;
	reg  [4:0]                fifo_size_reg;
	reg  [5:0]                count_reg;
	reg  [4:0]                sw_idx_reg;
	reg  [4:0]                can_idx_reg;
	reg  [31:0]               sw_address_reg;
	reg  [`NUM_EVENTS-1:0]    irq_status_reg;
	reg  [`NUM_EVENTS-1:0]    irq_enable_reg;
	reg  [`NUM_EVENTS-1:0]    flags_prev_reg;
	reg  [31:0]               rdata_reg;

	wire [3:0]                blk;
	wire [1:0]                op;
	wire                      config_mode;
	wire                      is_tx;
	wire [5:0]                depth;
	wire                      fifo_full;
	wire                      fifo_empty;
	wire [6:0]                count_x2;
	wire                      tx_space_flag;
	wire                      tx_half_flag;
	wire                      tx_drained_flag;
	wire                      rx_packed_flag;
	wire                      rx_half_flag;
	wire                      rx_pending_flag;
	wire                      rx_overrun_flag;
	wire [31:0]               flags_word;
	wire [31:0]               control_word;
	wire [31:0]               flags_new;
	wire [31:0]               control_new;
	wire                      wr_flags;
	wire                      wr_control;
	wire                      wr_irq_clear;
	wire                      wr_irq_enable;
	wire                      fifo_advance_pointer;
	wire                      producer_evt;
	wire                      consumer_evt;
	wire                      do_dec;
	wire                      do_inc;
	wire                      overrun_evt;
	wire                      sw_step;
	wire                      can_step;
	wire [12:0]               sw_offset;
	wire [31:0]               sw_address_next;
	wire [`NUM_EVENTS-1:0]    flags_vec;
	wire [`NUM_EVENTS-1:0]    irq_clear_vec;
	reg  [31:0]               rdata_next;

	assign blk         = addr_i[7:4];
	assign op          = addr_i[3:2];
	assign config_mode = (operating_mode_status_i == `OPMODE_CONFIG);
	assign is_tx       = fifo_direction_sel_reg;

	// Occupancy status
	assign depth      = {1'b0, fifo_size_reg} + 6'h01;
	assign fifo_full  = (count_reg == depth);
	assign fifo_empty = (count_reg == 6'h00);
	assign count_x2   = {count_reg, 1'b0};

	assign tx_space_flag   = is_tx & ~fifo_full;
	assign tx_half_flag    = is_tx & (count_x2 <= {1'b0, depth});
	assign tx_drained_flag = is_tx & fifo_empty;
	assign rx_packed_flag  = ~is_tx & fifo_full;
	assign rx_half_flag    = ~is_tx & (count_x2 >= {1'b0, depth});
	assign rx_pending_flag = ~is_tx & ~fifo_empty;
	assign rx_overrun_flag = ~is_tx & rx_overrun_flag_reg;

	assign flags_word = {5'h00,
			     tx_en_reg,
			     4'h0,
			     rx_en_reg,
			     5'h00,
			     tx_space_flag,
			     tx_half_flag,
			     tx_drained_flag,
			     4'h0,
			     rx_overrun_flag,
			     rx_packed_flag,
			     rx_half_flag,
			     rx_pending_flag};

	// Advance always reads back zero, so a set or invert alias still pulses it
	assign control_word = {11'h000,
			       fifo_size_reg,
			       8'h00,
			       fifo_direction_sel_reg,
			       7'h00};

	assign flags_new   = apply_op(op, flags_word, wdata_i);
	assign control_new = apply_op(op, control_word, wdata_i);

	assign wr_flags      = wr_i & (blk == `BLK_FLAGS_ENABLES);
	assign wr_control    = wr_i & (blk == `BLK_FIFO_CONTROL);
	assign wr_irq_clear  = wr_i & (blk == `BLK_IRQ) & (op == `IRQ_CLEAR_WORD);
	assign wr_irq_enable = wr_i & (blk == `BLK_IRQ) & (op == `IRQ_ENABLE_WORD);

	assign fifo_advance_pointer = wr_control & control_new[`FIFO_ADVANCE_BIT];

	// Transmit: software fills, CAN side drains; receive is the reverse
	assign producer_evt = ~config_mode & (is_tx ? fifo_advance_pointer : can_msg_done_i);
	assign consumer_evt = ~config_mode & (is_tx ? can_msg_done_i : fifo_advance_pointer);
	assign do_dec       = consumer_evt & ~fifo_empty;
	assign do_inc       = producer_evt & (~fifo_full | do_dec);
	assign overrun_evt  = ~is_tx & producer_evt & ~do_inc;
	assign sw_step      = is_tx ? do_inc : do_dec;
	assign can_step     = is_tx ? do_dec : do_inc;

	// Head for transmit, tail for receive: both are the software-side index
	assign sw_offset       = {8'h00, sw_idx_reg} * {5'h00, msg_bytes_i};
	assign sw_address_next = (fifo_base_addr_i + {19'h00000, sw_offset}) & 32'hfffffffc;

	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_en_reg <= 3'h0;
			rx_en_reg <= 4'h0;
		end
		else if (wr_flags)
		begin
			tx_en_reg <= flags_new[`TX_SPACE_EN_BIT:`TX_DRAINED_EN_BIT];
			rx_en_reg <= flags_new[`RX_OVERRUN_EN_BIT:`RX_PENDING_EN_BIT];
		end
	end

	// Overrun is the only writable flag; a new overrun beats a software clear
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			rx_overrun_flag_reg <= 1'b0;
		else if (overrun_evt)
			rx_overrun_flag_reg <= 1'b1;
		else if (wr_flags)
			rx_overrun_flag_reg <= flags_new[`RX_OVERRUN_FLAG_BIT];
		else if (config_mode)
			rx_overrun_flag_reg <= 1'b0;
	end

	// Direction and size only change in configuration, while pointers are cleared to zero
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fifo_direction_sel_reg <= 1'b0;
			fifo_size_reg          <= 5'h00;
		end
		else if (wr_control & config_mode)
		begin
			fifo_direction_sel_reg <= control_new[`FIFO_DIRECTION_BIT];
			fifo_size_reg          <= control_new[`FIFO_SIZE_MSB:`FIFO_SIZE_LSB];
		end
	end

	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			count_reg   <= 6'h00;
			sw_idx_reg  <= 5'h00;
			can_idx_reg <= 5'h00;
		end
		else if (config_mode)
		begin
			count_reg   <= 6'h00;
			sw_idx_reg  <= 5'h00;
			can_idx_reg <= 5'h00;
		end
		else
		begin
			if (do_inc & ~do_dec)
				count_reg <= count_reg + 6'h01;
			else if (do_dec & ~do_inc)
				count_reg <= count_reg - 6'h01;
			if (sw_step)
				sw_idx_reg <= (sw_idx_reg == fifo_size_reg) ? 5'h00 : sw_idx_reg + 5'h01;
			if (can_step)
				can_idx_reg <= (can_idx_reg == fifo_size_reg) ? 5'h00 : can_idx_reg + 5'h01;
		end
	end

	// Registered address; shows the aligned base during configuration since pointers are cleared
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			sw_address_reg <= 32'h00000000;
		else
			sw_address_reg <= sw_address_next;
	end

	// Sticky events on each flag's rising edge
	assign flags_vec     = {tx_space_flag,
				tx_half_flag,
				tx_drained_flag,
				rx_overrun_flag,
				rx_packed_flag,
				rx_half_flag,
				rx_pending_flag};
	assign irq_clear_vec = wr_irq_clear ? wdata_i[`NUM_EVENTS-1:0] : {`NUM_EVENTS{1'b0}};

	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			flags_prev_reg <= {`NUM_EVENTS{1'b0}};
		else
			flags_prev_reg <= flags_vec;
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_EVENTS; g = g + 1)
		begin : g_sticky
			always @(posedge clk_sys_i or posedge reset_i)
			begin
				if (reset_i)
					irq_status_reg[g] <= 1'b0;
				else if (flags_vec[g] & ~flags_prev_reg[g])
					irq_status_reg[g] <= 1'b1;
				else if (irq_clear_vec[g])
					irq_status_reg[g] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			irq_enable_reg <= `IRQ_ENABLE_RESET;
		else if (wr_irq_enable)
			irq_enable_reg <= wdata_i[`NUM_EVENTS-1:0];
	end

	assign irq_o = |(irq_status_reg & irq_enable_reg);

	assign fifo_irq_req_o = |({tx_space_flag,
				   tx_half_flag,
				   tx_drained_flag,
				   rx_overrun_flag,
				   rx_packed_flag,
				   rx_half_flag,
				   rx_pending_flag} &
				  {tx_en_reg, rx_en_reg});

	// Read decode; alias and unmapped words read zero
	always @*
	begin
		rdata_next = 32'h00000000;
		if (op != `OP_WRITE)
			rdata_next = 32'h00000000;
		else if (blk == `BLK_FLAGS_ENABLES)
			rdata_next = flags_word;
		else if (blk == `BLK_SW_ADDRESS)
			rdata_next = sw_address_reg;
		else if (blk == `BLK_FIFO_CONTROL)
			rdata_next = control_word;
		else if (blk == `BLK_IRQ)
			rdata_next = {25'h0000000, irq_status_reg};
		if ((blk == `BLK_IRQ) && (op == `IRQ_ENABLE_WORD))
			rdata_next = {25'h0000000, irq_enable_reg};
	end

	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_reg <= 32'h00000000;
		else if (rd_i)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= 32'h00000000;
	end

	assign rdata_o          = rdata_reg;
	assign can_side_index_o = can_idx_reg;

endmodule // can_fifo_status_irq

// File: testbench/can_fifo_status_irq_asserts.sv
`timescale 1ns/1ps
module can_fifo_status_irq_asserts (
	input wire        clk_sys_i,
	input wire        reset_i,
	input wire [7:0]  addr_i,
	input wire [31:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [31:0] rdata_o,
	input wire [2:0]  operating_mode_status_i,
	input wire [31:0] fifo_base_addr_i,
	input wire [7:0]  msg_bytes_i,
	input wire        can_msg_done_i,
	input wire [4:0]  can_side_index_o,
	input wire        fifo_irq_req_o,
	input wire        irq_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_alias_read_zero: assert property (rd_i && addr_i[3:2] != 2'h0 && addr_i[7:4] != 4'h3 |=> rdata_o == 32'h0)
		else $error("alias read returned data");
	a_address_low_zero: assert property (rd_i && addr_i == 8'h10 |=> rdata_o[1:0] == 2'h0)
		else $error("user address not aligned");
	a_flag_direction_split: assert property (rd_i && addr_i == 8'h00 |=> rdata_o[10:8] == 3'h0 || rdata_o[3:0] == 4'h0)
		else $error("tx and rx flags both active");
	a_tx_empty_order: assert property (rd_i && addr_i == 8'h00 ##1 rdata_o[8] |-> rdata_o[9] && rdata_o[10])
		else $error("empty tx fifo without half and space flags");
	a_rx_full_order: assert property (rd_i && addr_i == 8'h00 ##1 rdata_o[2] |-> rdata_o[1] && rdata_o[0])
		else $error("full rx fifo without half and pending flags");
	a_irq_enable_mask: assert property (wr_i && addr_i == 8'h38 && wdata_i[6:0] == 7'h0 |=> !irq_o)
		else $error("interrupt with all enables off");
	a_req_enable_mask: assert property (wr_i && addr_i == 8'h00 && wdata_i[26:24] == 3'h0 && wdata_i[19:16] == 4'h0 |=> !fifo_irq_req_o)
		else $error("fifo request with all enables off");
endmodule // can_fifo_status_irq_asserts

bind can_fifo_status_irq can_fifo_status_irq_asserts u_chk (.*);

// File: testbench/can_fifo_status_irq_bench.sv
`timescale 1ns/1ps
module can_fifo_status_irq_bench;
	reg         clk_sys_i;
	reg         reset_i;
	reg  [7:0]  addr_i;
	reg  [31:0] wdata_i;
	reg         wr_i;
	reg         rd_i;
	reg  [2:0]  operating_mode_status_i;
	reg         can_msg_done_i;
	wire [31:0] rdata_o;
	wire        fifo_irq_req_o;
	wire        irq_o;
	wire [4:0]  can_side_index_o;
	integer     num_errors;
	integer     samples_checked;

	can_fifo_status_irq dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.operating_mode_status_i(operating_mode_status_i),
		.fifo_base_addr_i(32'h20001003), .msg_bytes_i(8'h10), .can_msg_done_i(can_msg_done_i),
		.can_side_index_o(can_side_index_o),
		.fifo_irq_req_o(fifo_irq_req_o), .irq_o(irq_o));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task end_sim;
		begin
			$display("checks %0d errors %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp)
			begin
				num_errors = num_errors + 1;
				$display("Error t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_sys_i);
			wr_i <= 1'b1;
			addr_i <= a;
			wdata_i <= d;
			@(posedge clk_sys_i);
			wr_i <= 1'b0;
		end
	endtask

	task rd(input [7:0] a, input [31:0] e);
		begin
			@(posedge clk_sys_i);
			rd_i <= 1'b1;
			addr_i <= a;
			@(posedge clk_sys_i);
			rd_i <= 1'b0;
			#1 chk(rdata_o, e);
		end
	endtask

	// Pulse from the CAN side; one message moved
	task done_pulse;
		begin
			@(posedge clk_sys_i);
			can_msg_done_i <= 1'b1;
			@(posedge clk_sys_i);
			can_msg_done_i <= 1'b0;
		end
	endtask

	// Direction and size only stick in configuration mode; this also resets pointers
	task configure(input [31:0] ctl);
		begin
			@(posedge clk_sys_i);
			operating_mode_status_i <= 3'h4;
			wr(8'h20, ctl);
			// Back in normal mode before any user address read
			operating_mode_status_i <= 3'h0;
			@(posedge clk_sys_i);
		end
	endtask

	task enables_and_aliases;
		begin
			rd(8'h00, 32'h0);
			wr(8'h00, 32'hffffffff);
			rd(8'h00, 32'h070f0008);
			chk(fifo_irq_req_o, 32'h1);
			wr(8'h04, 32'h00000008);
			rd(8'h00, 32'h070f0000);
			wr(8'h0c, 32'h07000000);
			rd(8'h00, 32'h000f0000);
			wr(8'h08, 32'h00000001);
			rd(8'h00, 32'h000f0000);
			rd(8'h04, 32'h0);
		end
	endtask

	task rx_fill;
		begin
			configure(32'h00010000);
			done_pulse;
			rd(8'h00, 32'h000f0003);
			chk(fifo_irq_req_o, 32'h1);
			chk(can_side_index_o, 32'h1);
			done_pulse;
			rd(8'h00, 32'h000f0007);
			done_pulse;
			rd(8'h00, 32'h000f000f);
			chk(can_side_index_o, 32'h0);
			rd(8'h10, 32'h20001000);
			wr(8'h28, 32'h00002000);
			rd(8'h00, 32'h000f000b);
			rd(8'h10, 32'h20001010);
		end
	endtask

	task tx_drain;
		begin
			configure(32'h00010080);
			rd(8'h00, 32'h000f0700);
			chk(fifo_irq_req_o, 32'h0);
			wr(8'h08, 32'h04000000);
			#1 chk(fifo_irq_req_o, 32'h1);
			wr(8'h28, 32'h00002000);
			rd(8'h00, 32'h040f0600);
			rd(8'h10, 32'h20001010);
			wr(8'h28, 32'h00002000);
			rd(8'h00, 32'h040f0000);
			chk(fifo_irq_req_o, 32'h0);
			wr(8'h28, 32'h00002000);
			rd(8'h00, 32'h040f0000);
			done_pulse;
			rd(8'h00, 32'h040f0600);
			wr(8'h00, 32'h00000000);
			#1 chk(fifo_irq_req_o, 32'h0);
		end
	endtask

	task irq_status;
		begin
			rd(8'h30, 32'h0000007f);
			chk(irq_o, 32'h0);
			wr(8'h38, 32'h0000007f);
			#1 chk(irq_o, 32'h1);
			rd(8'h38, 32'h0000007f);
			wr(8'h38, 32'h00000000);
			#1 chk(irq_o, 32'h0);
			wr(8'h38, 32'h0000007f);
			#1 chk(irq_o, 32'h1);
			wr(8'h34, 32'h0000007f);
			rd(8'h30, 32'h0);
			chk(irq_o, 32'h0);
			rd(8'h3c, 32'h0);
		end
	endtask

	// Watchdog so a stuck run still reaches the verdict
	initial
	begin
		repeat (5000) @(posedge clk_sys_i);
		num_errors = num_errors + 1;
		end_sim;
	end

	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		reset_i = 1'b1;
		addr_i = 8'h0;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		operating_mode_status_i = 3'h0;
		can_msg_done_i = 1'b0;
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		chk(irq_o, 32'h0);
		enables_and_aliases;
		rx_fill;
		tx_drain;
		irq_status;
		end_sim;
	end
endmodule // can_fifo_status_irq_bench
